// ===== logic/spa_pair_arith.sv
`timescale 1ns/1ns
// Overview of operation
// - ED 01ss0010: pointer pair minus pair, carry
// - Selector: one, two, pointer, stack pointer
// - Subtract sets sign and zero from result
// - Subtract half flag from bit 12 borrow
// - Subtract sets overflow flag on overflow
// - Subtract sets N; carry from full borrow
// - DD 00rr1001 adds pair into first index
// - FD 00rr1001 adds pair into second index
// - First index add selects itself for 10
// - Second index add selects itself for 10
// - Index add: half from bit 11, N cleared
// - Index add: carry from bit 15
// - Index add keeps sign, zero, overflow
// - 00ss0011 increments pair, six states, no flags
// - 00ss1011 decrements pair, six states, no flags
// - DD 23 increments first index, ten states
// - FD 23 increments second index, ten states
// - DD 2B decrements first index, ten states
// - FD 2B decrements second index, ten states
module spa_pair_arith
  import spa_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic exec_valid,
  input wire logic [7:0] exec_prefix,
  input wire logic [7:0] exec_opcode,
  input wire spa_regs_s regs_in,
  input wire logic [7:0] flags_in,
  output spa_regs_s regs_out,
  output logic [7:0] flags_out,
  output logic done,
  output logic [3:0] states_out,
  output logic [2:0] mcycles_out,
  output logic illegal
);

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  spa_op_e op;
  logic [1:0] sel;
  assign sel = exec_opcode[5:4];

  always_comb begin
    op = SPA_NONE;
    if (exec_prefix == PFX_MISC) begin
      if ((exec_opcode & MASK_PAIR) == PAT_SBC) op = SPA_SBC;
    end else if (exec_prefix == PFX_IDX1 || exec_prefix == PFX_IDX2) begin
      if ((exec_opcode & MASK_PAIR) == PAT_ADD_IDX) begin
        op = (exec_prefix == PFX_IDX1) ? SPA_ADD_IDX1 : SPA_ADD_IDX2;
      end else if (exec_opcode == OP_IDX_INC) begin
        op = (exec_prefix == PFX_IDX1) ? SPA_INC_IDX1 : SPA_INC_IDX2;
      end else if (exec_opcode == OP_IDX_DEC) begin
        op = (exec_prefix == PFX_IDX1) ? SPA_DEC_IDX1 : SPA_DEC_IDX2;
      end
    end else begin
      // Any other prefix value means an unprefixed byte
      if ((exec_opcode & MASK_PAIR) == PAT_INC) op = SPA_INC;
      else if ((exec_opcode & MASK_PAIR) == PAT_DEC) op = SPA_DEC;
    end
  end

  // Selector 10 names the destination itself, so one function serves all
  function automatic logic [15:0] pick(input spa_regs_s r, input logic [1:0] s,
                                       input logic [15:0] self);
    case (s)
      SEL_ONE: pick = r.one;
      SEL_TWO: pick = r.two;
      SEL_PTR: pick = self;
      default: pick = r.sp;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Arithmetic
  // ---------------------------------------------------------------
  logic [15:0] src_gen, src_i1, src_i2, add_dst, add_src;
  logic [16:0] sbc_full, add_full;
  logic [12:0] sbc_low;
  logic [12:0] add_low;
  logic [15:0] sbc_res;
  logic cin;

  assign cin = flags_in[FLG_C];
  assign src_gen = pick(regs_in, sel, regs_in.ptr);
  assign src_i1 = pick(regs_in, sel, regs_in.idx1);
  assign src_i2 = pick(regs_in, sel, regs_in.idx2);
  assign add_dst = (op == SPA_ADD_IDX2) ? regs_in.idx2 : regs_in.idx1;
  assign add_src = (op == SPA_ADD_IDX2) ? src_i2 : src_i1;

  assign sbc_full = {1'b0, regs_in.ptr} - {1'b0, src_gen} - {16'h0000, cin};
  assign sbc_res = sbc_full[15:0];
  // Borrow out of the low twelve bits shows as the thirteenth bit
  assign sbc_low = {1'b0, regs_in.ptr[11:0]} - {1'b0, src_gen[11:0]} - {12'h000, cin};
  assign add_full = {1'b0, add_dst} + {1'b0, add_src};
  // Carry out of bit 11 shows as the thirteenth bit of the low sum
  assign add_low = {1'b0, add_dst[11:0]} + {1'b0, add_src[11:0]};

  function automatic logic [15:0] pair_step(input logic [15:0] v, input logic up);
    pair_step = up ? v + 16'h0001 : v - 16'h0001;
  endfunction

  // ---------------------------------------------------------------
  // Result registers
  // ---------------------------------------------------------------
  spa_regs_s regs_nxt;
  logic [7:0] flags_nxt;
  logic [3:0] states_nxt;
  logic [2:0] mc_nxt;
  logic [15:0] gen_step;

  always_comb begin
    regs_nxt = regs_in;
    flags_nxt = flags_in;
    states_nxt = 4'h0;
    mc_nxt = 3'h0;
    gen_step = pair_step(src_gen, op == SPA_INC);
    case (op)
      SPA_SBC: begin
        regs_nxt.ptr = sbc_res;
        flags_nxt[FLG_S] = sbc_res[15];
        flags_nxt[FLG_Z] = (sbc_res == 16'h0000);
        flags_nxt[FLG_H] = sbc_low[12];
        flags_nxt[FLG_PV] = (regs_in.ptr[15] != src_gen[15]) &&
                            (sbc_res[15] != regs_in.ptr[15]);
        flags_nxt[FLG_N] = 1'b1;
        flags_nxt[FLG_C] = sbc_full[16];
        states_nxt = ST_LONG;
        mc_nxt = MC_LONG;
      end
      SPA_ADD_IDX1, SPA_ADD_IDX2: begin
        if (op == SPA_ADD_IDX1) regs_nxt.idx1 = add_full[15:0];
        else regs_nxt.idx2 = add_full[15:0];
        // Sign, zero and overflow bits pass through untouched
        flags_nxt[FLG_H] = add_low[12];
        flags_nxt[FLG_N] = 1'b0;
        flags_nxt[FLG_C] = add_full[16];
        states_nxt = ST_LONG;
        mc_nxt = MC_LONG;
      end
      SPA_INC, SPA_DEC: begin
        case (sel)
          SEL_ONE: regs_nxt.one = gen_step;
          SEL_TWO: regs_nxt.two = gen_step;
          SEL_PTR: regs_nxt.ptr = gen_step;
          default: regs_nxt.sp = gen_step;
        endcase
        states_nxt = ST_STEP;
        mc_nxt = MC_STEP;
      end
      SPA_INC_IDX1, SPA_DEC_IDX1: begin
        regs_nxt.idx1 = pair_step(regs_in.idx1, op == SPA_INC_IDX1);
        states_nxt = ST_IDX_STEP;
        mc_nxt = MC_IDX_STEP;
      end
      SPA_INC_IDX2, SPA_DEC_IDX2: begin
        regs_nxt.idx2 = pair_step(regs_in.idx2, op == SPA_INC_IDX2);
        states_nxt = ST_IDX_STEP;
        mc_nxt = MC_IDX_STEP;
      end
      default: begin
      end
    endcase
  end

  // Results are held until the next accepted request
  always_ff @(posedge clk) begin
    if (!rstn) begin
      regs_out <= '{RST_WORD, RST_WORD, RST_WORD, RST_WORD, RST_WORD, RST_WORD};
      flags_out <= RST_FLAGS;
      states_out <= 4'h0;
      mcycles_out <= 3'h0;
    end else if (exec_valid) begin
      regs_out <= regs_nxt;
      flags_out <= flags_nxt;
      states_out <= states_nxt;
      mcycles_out <= mc_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      done <= 1'b0;
      illegal <= 1'b0;
    end else begin
      done <= exec_valid;
      illegal <= exec_valid && (op == SPA_NONE);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_sbc_time;
    @(posedge clk) disable iff (!rstn)
      exec_valid && op == SPA_SBC |=> states_out == 4'hf && mcycles_out == 3'h4 && done;
  endproperty
  a_sbc_time: assert property (p_sbc_time) else $error("sbc timing wrong");

  property p_sbc_result;
    @(posedge clk) disable iff (!rstn)
      exec_valid && op == SPA_SBC |=>
        regs_out.ptr == $past(regs_in.ptr) - $past(src_gen) - {15'h0000, $past(cin)};
  endproperty
  a_sbc_result: assert property (p_sbc_result) else $error("sbc result wrong");

  property p_sbc_zero;
    @(posedge clk) disable iff (!rstn)
      done && $past(op) == SPA_SBC |-> flags_out[FLG_Z] == (regs_out.ptr == 16'h0000)
        && flags_out[FLG_S] == regs_out.ptr[15];
  endproperty
  a_sbc_zero: assert property (p_sbc_zero) else $error("sbc sign/zero wrong");

  property p_sbc_nflag;
    @(posedge clk) disable iff (!rstn)
      exec_valid && op == SPA_SBC |=> flags_out[FLG_N];
  endproperty
  a_sbc_nflag: assert property (p_sbc_nflag) else $error("sbc N not set");

  property p_add_keep;
    @(posedge clk) disable iff (!rstn)
      exec_valid && (op == SPA_ADD_IDX1 || op == SPA_ADD_IDX2) |=>
        flags_out[FLG_S] == $past(flags_in[FLG_S]) && flags_out[FLG_Z] ==
        $past(flags_in[FLG_Z]) && flags_out[FLG_PV] == $past(flags_in[FLG_PV]) &&
        !flags_out[FLG_N];
  endproperty
  a_add_keep: assert property (p_add_keep) else $error("index add flags wrong");

  property p_add_idx1;
    @(posedge clk) disable iff (!rstn)
      exec_valid && op == SPA_ADD_IDX1 |=>
        regs_out.idx1 == $past(regs_in.idx1) + $past(src_i1) &&
        flags_out[FLG_C] == $past(add_full[16]) && mcycles_out == 3'h4;
  endproperty
  a_add_idx1: assert property (p_add_idx1) else $error("first index add wrong");

  property p_step_flags;
    @(posedge clk) disable iff (!rstn)
      exec_valid && (op == SPA_INC || op == SPA_DEC) |=>
        flags_out == $past(flags_in) && states_out == 4'h6 && mcycles_out == 3'h1;
  endproperty
  a_step_flags: assert property (p_step_flags) else $error("pair step wrong");

  property p_idx_step;
    @(posedge clk) disable iff (!rstn)
      exec_valid && op == SPA_DEC_IDX2 |=>
        regs_out.idx2 == $past(regs_in.idx2) - 16'h0001 && states_out == 4'ha
        && flags_out == $past(flags_in);
  endproperty
  a_idx_step: assert property (p_idx_step) else $error("second index step wrong");

  // Timing report shared by three of the four index step forms, all but the second index decrement
  sequence s_idx_timing;
    states_out == 4'ha && mcycles_out == 3'h2 && done;
  endsequence

  // Timing report used only by the second index addition check
  sequence s_long_timing;
    states_out == 4'hf && mcycles_out == 3'h4 && done;
  endsequence

  property p_sbc_half;
    @(posedge clk) disable iff (!rstn)
      exec_valid && op == SPA_SBC |=>
        flags_out[FLG_H] == ({1'b0, $past(regs_in.ptr[11:0])} <
        {1'b0, $past(src_gen[11:0])} + {12'h000, $past(cin)});
  endproperty
  a_sbc_half: assert property (p_sbc_half) else $error("sbc half flag wrong");

  property p_sbc_carry;
    @(posedge clk) disable iff (!rstn)
      exec_valid && op == SPA_SBC |=>
        flags_out[FLG_C] == ({1'b0, $past(regs_in.ptr)} <
        {1'b0, $past(src_gen)} + {16'h0000, $past(cin)});
  endproperty
  a_sbc_carry: assert property (p_sbc_carry) else $error("sbc carry wrong");

  property p_sbc_ovf;
    @(posedge clk) disable iff (!rstn)
      exec_valid && op == SPA_SBC |=>
        flags_out[FLG_PV] == (($past(regs_in.ptr[15]) != $past(src_gen[15])) &&
        (regs_out.ptr[15] != $past(regs_in.ptr[15])));
  endproperty
  a_sbc_ovf: assert property (p_sbc_ovf) else $error("sbc overflow wrong");

  property p_sel_gen;
    @(posedge clk) disable iff (!rstn)
      exec_valid && op == SPA_SBC && sel == SEL_TWO |-> src_gen == regs_in.two;
  endproperty
  a_sel_gen: assert property (p_sel_gen) else $error("pair selector wrong");

  property p_sel_idx1;
    @(posedge clk) disable iff (!rstn)
      exec_valid && op == SPA_ADD_IDX1 && sel == SEL_PTR |-> add_src == regs_in.idx1;
  endproperty
  a_sel_idx1: assert property (p_sel_idx1) else $error("first index selector wrong");

  property p_sel_idx2;
    @(posedge clk) disable iff (!rstn)
      exec_valid && op == SPA_ADD_IDX2 && sel == SEL_PTR |-> add_src == regs_in.idx2;
  endproperty
  a_sel_idx2: assert property (p_sel_idx2) else $error("second index selector wrong");

  property p_add_idx2;
    @(posedge clk) disable iff (!rstn)
      exec_valid && op == SPA_ADD_IDX2 |=>
        s_long_timing ##0 regs_out.idx2 == $past(regs_in.idx2) + $past(add_src);
  endproperty
  a_add_idx2: assert property (p_add_idx2) else $error("second index add wrong");

  property p_add_half;
    @(posedge clk) disable iff (!rstn)
      exec_valid && (op == SPA_ADD_IDX1 || op == SPA_ADD_IDX2) |=>
        flags_out[FLG_H] == ({1'b0, $past(add_dst[11:0])} +
        {1'b0, $past(add_src[11:0])} > 13'h0fff);
  endproperty
  a_add_half: assert property (p_add_half) else $error("index add half flag wrong");

  property p_add_carry;
    @(posedge clk) disable iff (!rstn)
      exec_valid && op == SPA_ADD_IDX2 |=>
        flags_out[FLG_C] == ({1'b0, $past(add_dst)} + {1'b0, $past(add_src)} > 17'h0ffff);
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("index add carry wrong");

  property p_dec_one;
    @(posedge clk) disable iff (!rstn)
      exec_valid && op == SPA_DEC && sel == SEL_ONE |=>
        regs_out.one == $past(regs_in.one) - 16'h0001 && states_out == 4'h6 &&
        flags_out == $past(flags_in);
  endproperty
  a_dec_one: assert property (p_dec_one) else $error("pair decrement wrong");

  property p_inc_idx1;
    @(posedge clk) disable iff (!rstn)
      exec_valid && op == SPA_INC_IDX1 |=>
        s_idx_timing ##0 regs_out.idx1 == $past(regs_in.idx1) + 16'h0001 &&
        flags_out == $past(flags_in);
  endproperty
  a_inc_idx1: assert property (p_inc_idx1) else $error("first index increment wrong");

  property p_inc_idx2;
    @(posedge clk) disable iff (!rstn)
      exec_valid && op == SPA_INC_IDX2 |=>
        s_idx_timing ##0 regs_out.idx2 == $past(regs_in.idx2) + 16'h0001 &&
        flags_out == $past(flags_in);
  endproperty
  a_inc_idx2: assert property (p_inc_idx2) else $error("second index increment wrong");

  property p_dec_idx1;
    @(posedge clk) disable iff (!rstn)
      exec_valid && op == SPA_DEC_IDX1 |=>
        s_idx_timing ##0 regs_out.idx1 == $past(regs_in.idx1) - 16'h0001 &&
        flags_out == $past(flags_in);
  endproperty
  a_dec_idx1: assert property (p_dec_idx1) else $error("first index decrement wrong");

  property p_wrap_down;
    @(posedge clk) disable iff (!rstn)
      exec_valid && op == SPA_DEC && sel == SEL_SP && regs_in.sp == 16'h0000 |=>
        regs_out.sp == 16'hffff;
  endproperty
  a_wrap_down: assert property (p_wrap_down) else $error("decrement wrap wrong");

  property p_wrap_up;
    @(posedge clk) disable iff (!rstn)
      exec_valid && op == SPA_INC && sel == SEL_ONE && regs_in.one == 16'hffff |=>
        regs_out.one == 16'h0000;
  endproperty
  a_wrap_up: assert property (p_wrap_up) else $error("increment wrap wrong");

endmodule

// ===== logic/spa_pkg.sv
package spa_pkg;
  // ---------------------------------------------------------------
  // Opcode bytes and patterns
  // ---------------------------------------------------------------
  localparam logic [7:0] PFX_MISC = 8'hed;
  localparam logic [7:0] PFX_IDX1 = 8'hdd;
  localparam logic [7:0] PFX_IDX2 = 8'hfd;
  localparam logic [7:0] OP_IDX_INC = 8'h23;
  localparam logic [7:0] OP_IDX_DEC = 8'h2b;
  localparam logic [7:0] MASK_PAIR = 8'hcf;
  localparam logic [7:0] PAT_SBC = 8'h42;
  localparam logic [7:0] PAT_ADD_IDX = 8'h09;
  localparam logic [7:0] PAT_INC = 8'h03;
  localparam logic [7:0] PAT_DEC = 8'h0b;
  // ---------------------------------------------------------------
  // Pair selector codes
  // ---------------------------------------------------------------
  localparam logic [1:0] SEL_ONE = 2'h0;
  localparam logic [1:0] SEL_TWO = 2'h1;
  localparam logic [1:0] SEL_PTR = 2'h2;
  localparam logic [1:0] SEL_SP = 2'h3;
  // ---------------------------------------------------------------
  // Flag bit positions and timing
  // ---------------------------------------------------------------
  localparam int FLG_C = 0;
  localparam int FLG_N = 1;
  localparam int FLG_PV = 2;
  localparam int FLG_H = 4;
  localparam int FLG_Z = 6;
  localparam int FLG_S = 7;
  localparam logic [3:0] ST_LONG = 4'hf;
  localparam logic [3:0] ST_IDX_STEP = 4'ha;
  localparam logic [3:0] ST_STEP = 4'h6;
  localparam logic [2:0] MC_LONG = 3'h4;
  localparam logic [2:0] MC_IDX_STEP = 3'h2;
  localparam logic [2:0] MC_STEP = 3'h1;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_FLAGS = 8'h00;

  typedef enum {SPA_SBC, SPA_ADD_IDX1, SPA_ADD_IDX2, SPA_INC, SPA_DEC,
    SPA_INC_IDX1, SPA_INC_IDX2, SPA_DEC_IDX1, SPA_DEC_IDX2, SPA_NONE} spa_op_e;

  typedef struct packed {
    logic [15:0] one;
    logic [15:0] two;
    logic [15:0] ptr;
    logic [15:0] sp;
    logic [15:0] idx1;
    logic [15:0] idx2;
  } spa_regs_s;
endpackage

// ===== testbench/sixteen_bit_pair_arithmetic_test.sv
`timescale 1ns/1ns
module sixteen_bit_pair_arithmetic_test
  import spa_pkg::*;
;
  logic clk, rstn, exec_valid, done, illegal;
  logic [7:0] exec_prefix, exec_opcode, flags_in, flags_out;
  logic [3:0] states_out;
  logic [2:0] mcycles_out;
  spa_regs_s regs_in, regs_out, ra, rb;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  spa_seq_model seq_u(.clk(clk), .exec_valid(exec_valid), .exec_prefix(exec_prefix),
    .exec_opcode(exec_opcode), .regs_in(regs_in), .flags_in(flags_in));
  spa_pair_arith dut_u(.clk(clk), .rstn(rstn), .exec_valid(exec_valid),
    .exec_prefix(exec_prefix), .exec_opcode(exec_opcode), .regs_in(regs_in),
    .flags_in(flags_in), .regs_out(regs_out), .flags_out(flags_out), .done(done),
    .states_out(states_out), .mcycles_out(mcycles_out), .illegal(illegal));
  // ----
  // Reference arithmetic
  // ----
  function automatic logic [15:0] pick(spa_regs_s r, logic [1:0] s, logic [15:0] me);
    case (s)
      SEL_ONE: return r.one;
      SEL_TWO: return r.two;
      SEL_PTR: return me;
      default: return r.sp;
    endcase
  endfunction
  function automatic spa_regs_s put(spa_regs_s r, logic [1:0] s, logic [15:0] v);
    case (s)
      SEL_ONE: r.one = v;
      SEL_TWO: r.two = v;
      SEL_PTR: r.ptr = v;
      default: r.sp = v;
    endcase
    return r;
  endfunction
  function automatic logic [23:0] sub_ref(logic [15:0] a, logic [15:0] b, logic [7:0] f);
    logic [16:0] d;
    logic [12:0] h;
    logic v;
    d = {1'b0, a} - {1'b0, b} - {16'h0, f[0]};
    h = {1'b0, a[11:0]} - {1'b0, b[11:0]} - {12'h0, f[0]};
    v = (a[15] != b[15]) && (d[15] != a[15]);
    return {d[15], d[15:0] == 16'h0, f[5], h[12], f[3], v, 1'b1, d[16], d[15:0]};
  endfunction
  function automatic logic [23:0] add_ref(logic [15:0] a, logic [15:0] b, logic [7:0] f);
    logic [16:0] s;
    logic [12:0] h;
    s = {1'b0, a} + {1'b0, b};
    h = {1'b0, a[11:0]} + {1'b0, b[11:0]};
    return {f[7:5], h[12], f[3:2], 1'b0, s[16], s[15:0]};
  endfunction
  // ----
  // Checks and transfers
  // ----
  task automatic cmp_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_regs(input spa_regs_s e);
    samples_checked++;
    if (regs_out !== e) begin
      n_mismatch++;
      $display("Error regs_out expected %h seen %h", e, regs_out);
    end
  endtask
  // Answer is due at the same edge that takes the strobe, one edge after it is raised
  task automatic run(input logic [7:0] p, input logic [7:0] o, input spa_regs_s r,
      input logic [7:0] f, input spa_regs_s e, input logic [7:0] ef,
      input logic [3:0] st, input logic [2:0] mc, input logic il);
    seq_u.issue(p, o, r, f);
    cmp_byte("done", 8'h01, {7'h0, done});
    cmp_byte("illegal", {7'h0, il}, {7'h0, illegal});
    cmp_regs(e);
    cmp_byte("flags_out", ef, flags_out);
    cmp_byte("states_out", {4'h0, st}, {4'h0, states_out});
    cmp_byte("mcycles_out", {5'h0, mc}, {5'h0, mcycles_out});
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_sbc(input spa_regs_s r, input logic [7:0] f);
    logic [23:0] x;
    for (int i = 0; i < 4; i++) begin
      x = sub_ref(r.ptr, pick(r, i[1:0], r.ptr), f);
      run(PFX_MISC, {2'b01, i[1:0], 4'h2}, r, f, put(r, SEL_PTR, x[15:0]), x[23:16],
          ST_LONG, MC_LONG, 1'b0);
    end
  endtask
  task automatic t_addx(input spa_regs_s r, input logic [7:0] f);
    logic [23:0] x;
    spa_regs_s e;
    for (int i = 0; i < 8; i++) begin
      e = r;
      if (i < 4) begin
        x = add_ref(r.idx1, pick(r, i[1:0], r.idx1), f);
        e.idx1 = x[15:0];
      end else begin
        x = add_ref(r.idx2, pick(r, i[1:0], r.idx2), f);
        e.idx2 = x[15:0];
      end
      run(i < 4 ? PFX_IDX1 : PFX_IDX2, {2'b00, i[1:0], 4'h9}, r, f, e, x[23:16],
          ST_LONG, MC_LONG, 1'b0);
    end
  endtask
  task automatic t_step(input spa_regs_s r, input logic [7:0] f);
    logic [15:0] v;
    for (int i = 0; i < 8; i++) begin
      v = pick(r, i[1:0], r.ptr);
      v = i[2] ? v - 16'h0001 : v + 16'h0001;
      run(8'h00, {2'b00, i[1:0], i[2], 3'h3}, r, f, put(r, i[1:0], v), f,
          ST_STEP, MC_STEP, 1'b0);
    end
  endtask
  task automatic t_xstep(input spa_regs_s r, input logic [7:0] f);
    spa_regs_s e;
    for (int i = 0; i < 4; i++) begin
      e = r;
      if (i[0]) e.idx2 = i[1] ? r.idx2 - 16'h0001 : r.idx2 + 16'h0001;
      else e.idx1 = i[1] ? r.idx1 - 16'h0001 : r.idx1 + 16'h0001;
      run(i[0] ? PFX_IDX2 : PFX_IDX1, i[1] ? OP_IDX_DEC : OP_IDX_INC, r, f, e, f,
          ST_IDX_STEP, MC_IDX_STEP, 1'b0);
    end
  endtask
  task automatic test_done;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    rstn = 1'b0;
    ra = '{16'h5555, 16'h1111, 16'h9999, 16'h8000, 16'h0333, 16'hf000};
    rb = '{16'hffff, 16'h0000, 16'hffff, 16'h0000, 16'hffff, 16'h8001};
    repeat (16) @(posedge clk);
    #1;
    rstn = 1'b1;
    cmp_byte("states_out", 8'h00, {4'h0, states_out});
    t_sbc(ra, 8'h00);
    t_sbc(ra, 8'hff);
    t_sbc(rb, 8'h29);
    t_addx(ra, 8'hff);
    t_addx(rb, 8'h00);
    t_step(ra, 8'hd5);
    t_step(rb, 8'h2a);
    t_xstep(ra, 8'h00);
    t_xstep(rb, 8'hff);
    run(PFX_MISC, 8'h00, ra, 8'h55, ra, 8'h55, 4'h0, 3'h0, 1'b1);
    test_done();
  end
endmodule

// ===== testbench/spa_seq_model.sv
`timescale 1ns/1ns
// ----
// Sequencer stand-in
// ----
module spa_seq_model
  import spa_pkg::*;
(
  input wire logic clk,
  output logic exec_valid,
  output logic [7:0] exec_prefix,
  output logic [7:0] exec_opcode,
  output spa_regs_s regs_in,
  output logic [7:0] flags_in
);
  initial begin
    exec_valid = 1'b0;
    exec_prefix = 8'h00;
    exec_opcode = 8'h00;
    regs_in = '0;
    flags_in = 8'h00;
  end
  // Released operands are inverted so stale values cannot pass
  task automatic issue(input logic [7:0] p, input logic [7:0] o,
                       input spa_regs_s r, input logic [7:0] f);
    @(posedge clk);
    #1;
    exec_valid = 1'b1;
    exec_prefix = p;
    exec_opcode = o;
    regs_in = r;
    flags_in = f;
    @(posedge clk);
    #1;
    exec_valid = 1'b0;
    exec_prefix = ~p;
    exec_opcode = ~o;
    regs_in = ~r;
    flags_in = ~f;
  endtask
endmodule
